// ==== hw/aescbe_defs.vh ====
/*
 * Constants shared by the block cipher engine files: mode encodings,
 * swap encodings, round count and field positions.
 * Assumes inclusion by bare name from the hw/ directory.
 */
`ifndef AESCBE_DEFS_VH
`define AESCBE_DEFS_VH

// ----------------------------------------------------------------------
// operation select encodings
// ----------------------------------------------------------------------
`define AESCBE_OP_ENC       2'h0
`define AESCBE_OP_DEC       2'h1
`define AESCBE_OP_KEYX      2'h2

// ----------------------------------------------------------------------
// chaining select encodings
// ----------------------------------------------------------------------
`define AESCBE_CH_ECB       2'h0
`define AESCBE_CH_CBC       2'h1
`define AESCBE_CH_CTR       2'h2

// ----------------------------------------------------------------------
// swap select encodings
// ----------------------------------------------------------------------
`define AESCBE_SW_NONE      2'h0
`define AESCBE_SW_HALF      2'h1
`define AESCBE_SW_BYTE      2'h2
`define AESCBE_SW_BIT       2'h3

// ----------------------------------------------------------------------
// round and field constants
// ----------------------------------------------------------------------
`define AESCBE_FIRST_ROUND  4'h1
`define AESCBE_LAST_ROUND   4'hA
`define AESCBE_RCON_BASE    4'hB
`define AESCBE_CTR_MSB      15
`define AESCBE_CTR_ONE      16'h0001
`define AESCBE_LAST_WORD    2'h3
`define AESCBE_GF_POLY      8'h1B
`define AESCBE_AFF_C        8'h63
`define AESCBE_INV_AFF_C    8'h05

`endif

// ==== hw/aescbe_sbox.v ====
/*
 * One byte substitution box, forward or inverse, computed from the
 * field inverse and the affine map instead of a lookup table.
 * Assumes a purely combinational context; no clock.
 */
`include "aescbe_defs.vh"

module aescbe_sbox (
   input  wire [7:0] i_byte,
   input  wire       i_inv,
   output wire [7:0] o_byte
);

   // ----------------------------------------------------------------------
   // field arithmetic
   // ----------------------------------------------------------------------
   function [7:0] gf_mul;
      input [7:0] a;
      input [7:0] b;
      reg   [7:0] p;
      reg   [7:0] x;
      integer     k;
      begin
         p = 8'h00;
         x = a;
         for (k = 0; k < 8; k = k + 1) begin
            if (b[k]) p = p ^ x;
            x = {x[6:0], 1'b0} ^ (x[7] ? `AESCBE_GF_POLY : 8'h00);
         end
         gf_mul = p;
      end
   endfunction

   // inverse as a^254; zero maps to zero for free
   function [7:0] gf_inv;
      input [7:0] a;
      reg   [7:0] p;
      reg   [7:0] r;
      integer     k;
      begin
         p = a;
         r = 8'h01;
         for (k = 1; k < 8; k = k + 1) begin
            p = gf_mul(p, p);
            r = gf_mul(r, p);
         end
         gf_inv = r;
      end
   endfunction

   // ----------------------------------------------------------------------
   // affine maps around one shared inverter
   // ----------------------------------------------------------------------
   wire [7:0] b = i_byte;
   wire [7:0] inv_aff = {b[6:0], b[7]} ^ {b[4:0], b[7:5]} ^ {b[1:0], b[7:2]}
                        ^ `AESCBE_INV_AFF_C;
   wire [7:0] g = gf_inv(i_inv ? inv_aff : b);
   wire [7:0] fwd_aff = g ^ {g[6:0], g[7]} ^ {g[5:0], g[7:6]} ^ {g[4:0], g[7:5]}
                        ^ {g[3:0], g[7:4]} ^ `AESCBE_AFF_C;

   assign o_byte = i_inv ? g : fwd_aff;

endmodule

// ==== hw/aescbe_mixcol.v ====
/*
 * One column of the column mixing step, forward or inverse.
 * Byte 0 of the column sits in bits 31:24. Purely combinational.
 */
`include "aescbe_defs.vh"

module aescbe_mixcol (
   input  wire [31:0] i_col,
   input  wire        i_inv,
   output wire [31:0] o_col
);

   // ----------------------------------------------------------------------
   // constant multipliers
   // ----------------------------------------------------------------------
   function [7:0] xt;
      input [7:0] a;
      begin
         xt = {a[6:0], 1'b0} ^ (a[7] ? `AESCBE_GF_POLY : 8'h00);
      end
   endfunction

   // k is the distance from the output row: coefficients 2,3,1,1 or e,b,d,9
   function [7:0] mc;
      input [7:0] a;
      input       inv;
      input [1:0] k;
      reg   [7:0] x2;
      reg   [7:0] x4;
      reg   [7:0] x8;
      begin
         x2 = xt(a);
         x4 = xt(x2);
         x8 = xt(x4);
         case (k)
            2'h0:    mc = inv ? (x8 ^ x4 ^ x2) : x2;
            2'h1:    mc = inv ? (x8 ^ x2 ^ a) : (x2 ^ a);
            2'h2:    mc = inv ? (x8 ^ x4 ^ a) : a;
            default: mc = inv ? (x8 ^ a) : a;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // four output bytes
   // ----------------------------------------------------------------------
   wire [7:0] cb [0:3];
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_byte
         assign cb[i] = i_col[31-8*i -: 8];
      end
      for (i = 0; i < 4; i = i + 1) begin : g_out
         assign o_col[31-8*i -: 8] = mc(cb[i], i_inv, 2'h0)
                                   ^ mc(cb[(i+1)%4], i_inv, 2'h1)
                                   ^ mc(cb[(i+2)%4], i_inv, 2'h2)
                                   ^ mc(cb[(i+3)%4], i_inv, 2'h3);
      end
   endgenerate

endmodule

// ==== hw/aescbe_engine.v ====
/*
 * 128-bit block cipher engine: iterative one-round-per-cycle datapath
 * with on-the-fly round keys, ECB/CBC/CTR chaining, key expansion and
 * an input/output word swapper. Software strobes reach it as plain ports.
 * Assumes one clock, synchronous active-low reset, synchronous inputs.
 */
// Notes on behaviour
// - one 128-bit block, 128-bit key per operation
// - ECB, CBC, CTR picked by two-bit field
// - mode and swap fields frozen while enabled
// - ECB ignores the vector, blocks independent
// - CBC encrypt xors previous ciphertext, vector first
// - CTR ciphers nonce plus counter, xors input
// - CTR counter increments once per block
// - CTR always uses the forward key schedule
// - half-word, byte, bit swap on data ports only
// - operation codes: encrypt 00, decrypt 01, expand 10
// - done flag set when the block finishes
// - back-to-back blocks keep chaining state across
// - expansion ignores chaining and vector, derives key
// - expansion end sets done and clears enable
// - derived key shown on expanded key outputs
// - key word 0 holds bits 31:0
// - fourth input write while enabled starts block
`include "aescbe_defs.vh"

module aescbe_engine (
   input  wire         i_sys_clk,
   input  wire         i_rst_n,
   input  wire         i_ctrl_wr,
   input  wire         i_cipher_enable,
   input  wire [1:0]   i_operation_select,
   input  wire [1:0]   i_chaining_select,
   input  wire [1:0]   i_swap_select,
   input  wire         i_done_clear,
   input  wire         i_key_wr,
   input  wire         i_iv_wr,
   input  wire [1:0]   i_word_sel,
   input  wire [31:0]  i_wdata,
   input  wire         i_in_wr,
   input  wire         i_out_rd,
   output wire         o_cipher_enable,
   output wire [1:0]   o_operation_select,
   output wire [1:0]   o_chaining_select,
   output wire [1:0]   o_swap_select,
   output wire         o_block_done_flag,
   output wire         o_busy,
   output wire [127:0] o_key_words,
   output wire [127:0] o_init_vector_words,
   output wire [127:0] o_expanded_key_words,
   output wire [31:0]  o_out_word
);

   // ----------------------------------------------------------------------
   // states and helpers
   // ----------------------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN  = 2'h1;
   localparam ST_FIN  = 2'h2;

   // swap applied to data port words only, never to key or vector
   function [31:0] swap_word;
      input [31:0] w;
      input [1:0]  sel;
      integer      k;
      begin
         swap_word = w;
         case (sel)
            `AESCBE_SW_HALF: swap_word = {w[15:0], w[31:16]};
            `AESCBE_SW_BYTE: swap_word = {w[7:0], w[15:8], w[23:16], w[31:24]};
            `AESCBE_SW_BIT: begin
               for (k = 0; k < 32; k = k + 1) swap_word[k] = w[31-k];
            end
            default: swap_word = w;
         endcase
      end
   endfunction

   function [7:0] rcon;
      input [3:0] r;
      begin
         case (r)
            4'h9:    rcon = 8'h1B;
            4'hA:    rcon = 8'h36;
            // below nine a plain power of two; out of range shifts to zero
            default: rcon = 8'h01 << (r - 4'h1);
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   reg         en_q;
   reg [1:0]   op_q;
   reg [1:0]   chn_q;
   reg [1:0]   swp_q;
   reg         flag_q;
   reg [127:0] key_q;
   reg [127:0] iv_q;
   reg [127:0] exp_q;
   reg [127:0] din_q;
   reg [127:0] chain_q;
   reg [127:0] st_q;
   reg [127:0] rk_q;
   reg [127:0] res_q;
   reg [31:0]  out_q;
   reg [3:0]   rnd_q;
   reg [1:0]   fsm_q;
   reg [1:0]   in_cnt_q;
   reg [1:0]   rd_idx_q;
   reg         dec_q;
   reg         kx_q;

   // ----------------------------------------------------------------------
   // input assembly and chaining front end
   // ----------------------------------------------------------------------
   wire [31:0]  sw_in   = swap_word(i_wdata, swp_q);
   wire [127:0] blk     = {din_q[95:0], sw_in};
   wire         is_ctr  = (chn_q == `AESCBE_CH_CTR);
   wire         is_cbc  = (chn_q == `AESCBE_CH_CBC);
   wire         use_dec = (op_q == `AESCBE_OP_DEC) && !is_ctr;
   // input writes only while enabled, idle and not expanding
   wire         accept  = i_in_wr && en_q && (fsm_q == ST_IDLE)
                          && (op_q != `AESCBE_OP_KEYX);
   wire         start_blk = accept && (in_cnt_q == `AESCBE_LAST_WORD);
   wire         en_rise = i_ctrl_wr && !en_q && i_cipher_enable;
   wire         start_kx = en_rise && (i_operation_select == `AESCBE_OP_KEYX);

   // ECB passes the block straight in and never looks at the vector
   wire [127:0] core_in = is_ctr ? chain_q :
                          (is_cbc && !use_dec) ? (blk ^ chain_q) :
                          blk;

   // ----------------------------------------------------------------------
   // round key step, forward or backward
   // ----------------------------------------------------------------------
   wire [31:0] w0 = rk_q[127:96];
   wire [31:0] w1 = rk_q[95:64];
   wire [31:0] w2 = rk_q[63:32];
   wire [31:0] w3 = rk_q[31:0];
   wire [3:0]  rc_idx = dec_q ? (`AESCBE_RCON_BASE - rnd_q) : rnd_q;
   wire [31:0] ks_in  = dec_q ? (w3 ^ w2) : w3;
   wire [31:0] ks_rot = {ks_in[23:0], ks_in[31:24]};
   wire [31:0] ks_sub;
   wire [31:0] ks_t   = ks_sub ^ {rcon(rc_idx), 24'h000000};
   wire [31:0] n0     = w0 ^ ks_t;
   wire [31:0] n1     = w1 ^ n0;
   wire [31:0] n2     = w2 ^ n1;
   wire [31:0] n3     = w3 ^ n2;
   wire [127:0] nk    = {n0, n1, n2, n3};
   wire [127:0] pk    = {w0 ^ ks_t, w1 ^ w0, w2 ^ w1, w3 ^ w2};

   // ----------------------------------------------------------------------
   // state round: substitute, shift, mix, add key
   // ----------------------------------------------------------------------
   wire [7:0]   sb [0:15];
   wire [127:0] sh;
   wire [127:0] mix_out;
   wire [127:0] mix_in = dec_q ? (sh ^ pk) : sh;

   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : g_ks
         aescbe_sbox u_ks_sbox (
            .i_byte (ks_rot[31-8*i -: 8]),
            .i_inv  (1'b0),
            .o_byte (ks_sub[31-8*i -: 8])
         );
      end
      // substitution is bytewise, so it may run ahead of the row shift
      for (i = 0; i < 16; i = i + 1) begin : g_sb
         aescbe_sbox u_st_sbox (
            .i_byte (st_q[127-8*i -: 8]),
            .i_inv  (dec_q),
            .o_byte (sb[i])
         );
         assign sh[127-8*i -: 8] = dec_q ?
            sb[4*(((i/4) + 4 - (i%4)) % 4) + (i%4)] :
            sb[4*(((i/4) + (i%4)) % 4) + (i%4)];
      end
      for (i = 0; i < 4; i = i + 1) begin : g_mc
         aescbe_mixcol u_mixcol (
            .i_col (mix_in[127-32*i -: 32]),
            .i_inv (dec_q),
            .o_col (mix_out[127-32*i -: 32])
         );
      end
   endgenerate

   wire         last   = (rnd_q == `AESCBE_LAST_ROUND);
   wire [127:0] st_nxt = dec_q ? (last ? (sh ^ pk) : mix_out)
                               : ((last ? sh : mix_out) ^ nk);

   // result back end: undo chaining around the core output
   wire [127:0] res = is_ctr ? (st_q ^ din_q) :
                      (is_cbc && use_dec) ? (st_q ^ chain_q) : st_q;
   wire [127:0] rd_nxt = res_q << {rd_idx_q + 2'h1, 5'h00};              // next word on top

   // ----------------------------------------------------------------------
   // control, sequencing and data registers
   // ----------------------------------------------------------------------
   always @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         en_q     <= 1'b0;
         op_q     <= `AESCBE_OP_ENC;
         chn_q    <= `AESCBE_CH_ECB;
         swp_q    <= `AESCBE_SW_NONE;
         flag_q   <= 1'b0;
         key_q    <= 128'h0;
         iv_q     <= 128'h0;
         exp_q    <= 128'h0;
         din_q    <= 128'h0;
         chain_q  <= 128'h0;
         st_q     <= 128'h0;
         rk_q     <= 128'h0;
         res_q    <= 128'h0;
         out_q    <= 32'h00000000;
         rnd_q    <= 4'h0;
         fsm_q    <= ST_IDLE;
         in_cnt_q <= 2'h0;
         rd_idx_q <= 2'h0;
         dec_q    <= 1'b0;
         kx_q     <= 1'b0;
      end else begin
         // key and vector words, word 0 is the least significant
         if (i_key_wr) key_q[32*i_word_sel +: 32] <= i_wdata;
         if (i_iv_wr) iv_q[32*i_word_sel +: 32] <= i_wdata;

         // control write; fields only move while enable reads zero
         if (i_ctrl_wr) begin
            if (!en_q) begin
               op_q  <= i_operation_select;
               chn_q <= i_chaining_select;
               swp_q <= i_swap_select;
            end
            en_q <= i_cipher_enable;
            if (en_rise) begin
               chain_q  <= iv_q;
               in_cnt_q <= 2'h0;
            end
            // dropping enable abandons a block still in its rounds; one in its finish step completes
            if (en_q && !i_cipher_enable) begin
               fsm_q    <= ST_IDLE;
               in_cnt_q <= 2'h0;
            end
         end

         // done flag: a set in the same cycle beats the clear
         if (fsm_q == ST_FIN) begin
            flag_q <= 1'b1;
         end else if (i_ctrl_wr && i_done_clear) begin
            flag_q <= 1'b0;
         end

         // input word collection
         if (accept) begin
            din_q    <= blk;
            in_cnt_q <= in_cnt_q + 2'h1;
         end

         if (start_kx) begin
            rk_q  <= key_q;
            rnd_q <= `AESCBE_FIRST_ROUND;
            dec_q <= 1'b0;
            kx_q  <= 1'b1;
            fsm_q <= ST_RUN;
         end else if (start_blk) begin
            st_q  <= core_in ^ key_q;
            rk_q  <= key_q;
            rnd_q <= `AESCBE_FIRST_ROUND;
            dec_q <= use_dec;
            kx_q  <= 1'b0;
            fsm_q <= ST_RUN;
         end else begin
            case (fsm_q)
               ST_RUN: begin
                  if (!(i_ctrl_wr && !i_cipher_enable)) begin
                     st_q  <= st_nxt;
                     rk_q  <= dec_q ? pk : nk;
                     rnd_q <= rnd_q + 4'h1;
                     if (last) fsm_q <= ST_FIN;
                  end
               end
               ST_FIN: begin
                  fsm_q <= ST_IDLE;
                  if (kx_q) begin
                     exp_q <= rk_q;
                     en_q  <= 1'b0;
                  end else begin
                     res_q    <= res;
                     out_q    <= swap_word(res[127:96], swp_q);
                     rd_idx_q <= 2'h0;
                     // chaining state carried to the next block
                     if (is_cbc) begin
                        chain_q <= use_dec ? din_q : st_q;
                     end else if (is_ctr) begin
                        chain_q[`AESCBE_CTR_MSB:0] <= chain_q[`AESCBE_CTR_MSB:0]
                                                    + `AESCBE_CTR_ONE;
                     end
                  end
               end
               default: fsm_q <= ST_IDLE;
            endcase
         end

         // result readout, one word per read strobe, high word first
         if (i_out_rd && (fsm_q != ST_FIN) && (rd_idx_q != `AESCBE_LAST_WORD)) begin
            rd_idx_q <= rd_idx_q + 2'h1;
            out_q    <= swap_word(rd_nxt[127:96], swp_q);
         end
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign o_cipher_enable      = en_q;
   assign o_operation_select   = op_q;
   assign o_chaining_select    = chn_q;
   assign o_swap_select        = swp_q;
   assign o_block_done_flag    = flag_q;
   assign o_busy               = (fsm_q != ST_IDLE);
   assign o_key_words          = key_q;
   assign o_init_vector_words  = iv_q;
   assign o_expanded_key_words = exp_q;
   assign o_out_word           = out_q;

endmodule

// ==== testbench/aescbe_engine_chk.sv ====
/*
 * Port-level assertions for the block cipher engine: busy length, done
 * flag timing, frozen mode fields and key word write-back.
 * Assumes binding onto aescbe_engine; one clock, synchronous reset.
 */
module aescbe_chk (
   input wire logic         i_sys_clk,
   input wire logic         i_rst_n,
   input wire logic         i_ctrl_wr,
   input wire logic         i_cipher_enable,
   input wire logic [1:0]   i_operation_select,
   input wire logic         i_done_clear,
   input wire logic         i_key_wr,
   input wire logic [1:0]   i_word_sel,
   input wire logic [31:0]  i_wdata,
   input wire logic         o_cipher_enable,
   input wire logic [1:0]   o_operation_select,
   input wire logic [1:0]   o_chaining_select,
   input wire logic [1:0]   o_swap_select,
   input wire logic         o_block_done_flag,
   input wire logic         o_busy,
   input wire logic [127:0] o_key_words
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // clocking and step sequences
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ten rounds plus one finish step; split since repeats stay small
   sequence busy_run;
      o_busy[*8] ##1 o_busy[*3];
   endsequence
   sequence keyx_req;
      i_ctrl_wr && i_cipher_enable && !o_cipher_enable && !o_busy && i_operation_select == 2'h2;
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   busy_length_a : assert property ($rose(o_busy) |-> busy_run ##1 !o_busy)
      else $error("busy did not last eleven cycles");
   busy_cause_a : assert property ($rose(o_busy) |-> $past(i_ctrl_wr) || $past(o_cipher_enable))
      else $error("busy rose without a request");
   idle_disabled_a : assert property (!o_cipher_enable && !i_ctrl_wr |=> !o_busy)
      else $error("busy while disabled");
   keyx_start_a : assert property (keyx_req |=> o_busy)
      else $error("expansion did not start on enable");
   keyx_end_a : assert property ($fell(o_busy) && o_operation_select == 2'h2 |-> !o_cipher_enable)
      else $error("enable not cleared after expansion");
   done_at_end_a : assert property ($rose(o_block_done_flag) |-> $fell(o_busy))
      else $error("done flag rose away from block end");
   done_sticky_a : assert property (o_block_done_flag && !i_ctrl_wr |=> o_block_done_flag)
      else $error("done flag dropped by itself");
   done_clear_a : assert property (i_ctrl_wr && i_done_clear && !o_busy |=> !o_block_done_flag)
      else $error("done flag not cleared");
   fields_frozen_a : assert property (o_cipher_enable |=> $stable(o_operation_select) && $stable(o_chaining_select) && $stable(o_swap_select))
      else $error("mode field changed while enabled");
   key_top_word_a : assert property (i_key_wr && i_word_sel == 2'h3 |=> o_key_words[127:96] == $past(i_wdata))
      else $error("key word three not written");
endmodule

bind aescbe_engine aescbe_chk chk_u (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ctrl_wr(i_ctrl_wr),
   .i_cipher_enable(i_cipher_enable), .i_operation_select(i_operation_select),
   .i_done_clear(i_done_clear), .i_key_wr(i_key_wr), .i_word_sel(i_word_sel),
   .i_wdata(i_wdata), .o_cipher_enable(o_cipher_enable),
   .o_operation_select(o_operation_select), .o_chaining_select(o_chaining_select),
   .o_swap_select(o_swap_select), .o_block_done_flag(o_block_done_flag),
   .o_busy(o_busy), .o_key_words(o_key_words)
);

// ==== testbench/aescbe_engine_tb.sv ====
/*
 * Self-checking bench for the block cipher engine: known-answer blocks
 * through every swap, chaining mode and operation.
 * Assumes the engine ports as plain strobes and a 10 MHz clock.
 */
module aescbe_engine_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [127:0] K1 = 128'h000102030405060708090A0B0C0D0E0F;
   localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
   localparam logic [127:0] CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
   localparam logic [127:0] DK = 128'h13111D7FE3944A17F307A78B4D2B30C5;
   logic i_sys_clk, i_rst_n, i_ctrl_wr, i_cipher_enable, i_done_clear;
   logic i_key_wr, i_iv_wr, i_in_wr, i_out_rd;
   logic [1:0] i_operation_select, i_chaining_select, i_swap_select, i_word_sel, swv;
   logic [31:0] i_wdata, o_out_word;
   logic [127:0] o_key_words, o_init_vector_words, o_expanded_key_words, last, x1, x2;
   logic o_cipher_enable, o_block_done_flag, o_busy;
   logic [1:0] o_operation_select, o_chaining_select, o_swap_select;
   int error_cnt, n_compared;
   aescbe_engine dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ctrl_wr(i_ctrl_wr),
      .i_cipher_enable(i_cipher_enable), .i_operation_select(i_operation_select),
      .i_chaining_select(i_chaining_select), .i_swap_select(i_swap_select),
      .i_done_clear(i_done_clear), .i_key_wr(i_key_wr), .i_iv_wr(i_iv_wr),
      .i_word_sel(i_word_sel), .i_wdata(i_wdata), .i_in_wr(i_in_wr), .i_out_rd(i_out_rd),
      .o_cipher_enable(o_cipher_enable), .o_operation_select(o_operation_select),
      .o_chaining_select(o_chaining_select), .o_swap_select(o_swap_select),
      .o_block_done_flag(o_block_done_flag), .o_busy(o_busy), .o_key_words(o_key_words),
      .o_init_vector_words(o_init_vector_words),
      .o_expanded_key_words(o_expanded_key_words), .o_out_word(o_out_word));
   // ----------------------------------------------------------------
   // clock and helpers
   // ----------------------------------------------------------------
   initial begin
      i_sys_clk = 1'b0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   // inputs move 1 ns after the edge so no race with the design
   task automatic tick;
      @(posedge i_sys_clk);
      #1;
   endtask
   task automatic wrap_up;
      if (error_cnt == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // all three swaps are their own inverse
   function automatic logic [31:0] swp(input logic [31:0] w);
      logic [31:0] r;
      r = w;
      if (swv == 2'h1) r = {w[15:0], w[31:16]};
      if (swv == 2'h2) r = {w[7:0], w[15:8], w[23:16], w[31:24]};
      if (swv == 2'h3) for (int i = 0; i < 32; i++) r[i] = w[31 - i];
      return r;
   endfunction
   task automatic ctrl(input logic en, input logic [1:0] op, ch, input logic clr);
      {i_ctrl_wr, i_cipher_enable, i_done_clear} = {1'b1, en, clr};
      {i_operation_select, i_chaining_select, i_swap_select} = {op, ch, swv};
      tick();
      {i_ctrl_wr, i_done_clear} = 2'h0;
      tick();
   endtask
   // first write disables, second lands the fields
   task automatic setup(input logic [1:0] op, ch);
      ctrl(1'b0, op, ch, 1'b0);
      ctrl(1'b0, op, ch, 1'b0);
   endtask
   task automatic wreg(input logic iv, input logic [127:0] v);
      for (int i = 0; i < 4; i++) begin
         {i_key_wr, i_iv_wr, i_word_sel, i_wdata} = {~iv, iv, 2'(i), v[32*i +: 32]};
         tick();
      end
      {i_key_wr, i_iv_wr} = 2'h0;
      tick();
   endtask
   task automatic wait_done;
      int k;
      k = 0;
      while (o_block_done_flag !== 1'b1 && k < 40) begin
         tick();
         k++;
      end
      if (k == 40) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   // one block: four words high first, a stray write while busy, four reads
   task automatic blk(input logic [127:0] din, exp, input logic check);
      for (int i = 0; i < 5; i++) begin
         i_wdata = (i < 4) ? swp(din[127 - 32*i -: 32]) : $urandom;
         i_in_wr = 1'b1;
         tick();
      end
      i_in_wr = 1'b0;
      wait_done();
      for (int i = 0; i < 4; i++) begin
         last[127 - 32*i -: 32] = swp(o_out_word);
         i_out_rd = 1'b1;
         tick();
      end
      i_out_rd = 1'b0;
      if (check) chk(last, exp);
      ctrl(1'b1, 2'h0, 2'h0, 1'b1);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {i_rst_n, i_ctrl_wr, i_cipher_enable, i_done_clear, i_key_wr, i_iv_wr} = 6'h0;
      {i_in_wr, i_out_rd, i_operation_select, i_chaining_select} = 6'h0;
      {i_swap_select, i_word_sel, i_wdata, swv} = 38'h0;
      {error_cnt, n_compared} = 0;
      void'($urandom(32'hEA242136));
      repeat (6) tick();
      chk(o_key_words | o_init_vector_words | o_expanded_key_words, 128'h0);
      chk(128'({o_out_word, o_cipher_enable, o_operation_select, o_busy, o_block_done_flag,
                o_chaining_select, o_swap_select}), 128'h0);
      i_rst_n = 1'b1;
      for (int s = 0; s < 4; s++) begin
         swv = 2'(s);
         setup(2'h0, 2'h0);
         wreg(1'b0, K1);
         wreg(1'b1, {$urandom, $urandom, $urandom, $urandom});
         ctrl(1'b1, 2'h0, 2'h0, 1'b0);
         blk(PT, CT, 1'b1);
      end
      swv = 2'($urandom);
      ctrl(1'b1, 2'($urandom), 2'($urandom), 1'b0);
      swv = 2'h3;
      chk(128'({o_operation_select, o_chaining_select, o_swap_select}), 128'h3);
      blk(PT, CT, 1'b1);
      swv = 2'h0;
      setup(2'h0, 2'h1);
      wreg(1'b1, 128'h0);
      ctrl(1'b1, 2'h0, 2'h1, 1'b0);
      blk(PT, CT, 1'b1);
      blk(PT ^ CT, CT, 1'b1);
      setup(2'h2, 2'($urandom));
      wreg(1'b1, {$urandom, $urandom, $urandom, $urandom});
      ctrl(1'b1, 2'h2, 2'h1, 1'b0);
      wait_done();
      chk(o_expanded_key_words, DK);
      chk(128'(o_cipher_enable), 128'h0);
      ctrl(1'b0, 2'h2, 2'h0, 1'b1);
      setup(2'h1, 2'h0);
      wreg(1'b0, DK);
      ctrl(1'b1, 2'h1, 2'h0, 1'b0);
      blk(CT, PT, 1'b1);
      setup(2'h1, 2'h1);
      wreg(1'b1, 128'h0);
      ctrl(1'b1, 2'h1, 2'h1, 1'b0);
      blk(CT, PT, 1'b1);
      blk(CT, PT ^ CT, 1'b1);
      x1 = {$urandom, $urandom, $urandom, $urandom};
      x2 = {$urandom, $urandom, $urandom, $urandom};
      setup(2'h0, 2'h2);
      wreg(1'b0, K1);
      wreg(1'b1, PT - 128'h1);
      ctrl(1'b1, 2'h0, 2'h2, 1'b0);
      blk(x2, 128'h0, 1'b0);
      chk(128'((last ^ x2) !== CT), 128'h1);
      blk(x1, x1 ^ CT, 1'b1);
      setup(2'h1, 2'h2);
      ctrl(1'b1, 2'h1, 2'h2, 1'b0);
      blk(x2, 128'h0, 1'b0);
      blk(x1 ^ CT, x1, 1'b1);
      wrap_up();
   end
endmodule
